// File: hw/dps_regs.vh
`ifndef DPS_REGS_VH
`define DPS_REGS_VH
// register byte offsets
`define DPS_OFF_CTRL      8'h00
`define DPS_OFF_FUNC      8'h04
`define DPS_OFF_LOSS      8'h08
`define DPS_OFF_THR       8'h0c
`define DPS_OFF_BRAKE     8'h10
`define DPS_OFF_OUTSEL    8'h14
`define DPS_OFF_STATUS    8'h18
`define DPS_OFF_IRQ_STAT  8'h1c
`define DPS_OFF_IRQ_MASK  8'h20
`define DPS_OFF_ANALOG    8'h24
// input function codes
`define DPS_FN_MAX        5'd27
`define DPS_FN_TRIP_NO    5'd18
`define DPS_FN_TRIP_NC    5'd19
`define DPS_FN4_RST       5'd3
`define DPS_FN5_RST       5'd4
`define DPS_FN1_RST       5'd0
// output function codes
`define DPS_OUT_OVL       5'd6
`define DPS_OUT_LOSS      5'd11
`define DPS_OUT_MAX       5'd19
`define DPS_OUT_RST       5'd17
// loss supervision
`define DPS_LT_MIN        11'd1
`define DPS_LT_MAX        11'd1200
`define DPS_LT_RST        11'd10
`define DPS_REF_V1        3'd3
`define DPS_REF_VI        3'd6
`define DPS_REF_COMM      3'd7
// braking
`define DPS_DUTY_MAX      5'd30
`define DPS_DUTY_RST      5'd10
`define DPS_BRK_MAX_S     15
// timing
`define DPS_TENTH_S_NS    100000000
`define DPS_CLK_NS        5
`endif

// File: hw/dps_supervisor.v
// How it works
// RULE1: n.o. trip input closed to common blocks output and records trip
// RULE2: n.c. trip input opened from common blocks output and records trip
// RULE3: n.c. trip holds until its input recloses, despite reassignment
// RULE4: selectors take 0..27; input four defaults 3, input five 4
// RULE5: inputs four and five only usable on the extended variant
// RULE6: current over rating trips overload after inverse-time delay
// RULE7: output code 6 shows overload trip
// RULE8: loss supervised only for analog or communication references
// RULE9: loss mode 0 off, 1 below half threshold, 2 below threshold
// RULE10: combined source: loss if either input is below its threshold
// RULE11: react only after loss persists 0.1..120 s, default 1 s
// RULE12: reaction 0 keeps running, 1 blocks output, 2 decelerating stop
// RULE13: output code 11 shows detected reference loss
// RULE14: limit 0 brakes unlimited, 1 restricts to duty
// RULE15: duty 0..30 %, default 10, applied only with limit on
// RULE16: duty is the on fraction of one operation cycle
// RULE17: brake signal ends after 15 s continuous
// RULE18: trips latch until condition gone and fault reset
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "dps_regs.vh"
module dps_supervisor #(
   parameter        EXTENDED_IO  = 1,
   parameter        TENTH_CYC    = `DPS_TENTH_S_NS / `DPS_CLK_NS,
   parameter        BRK_CYC      = `DPS_BRK_MAX_S * 10,
   parameter        DUTY_PERIOD  = 100,
   parameter [31:0] OVL_BUDGET   = 32'd200000000
) (
   input  wire        clk_in,
   input  wire        sys_rst_in,
   input  wire        clk_en_in,
   input  wire [4:0]  multi_input_in,
   input  wire [11:0] voltage_reference_input_in,
   input  wire [11:0] second_voltage_input_in,
   input  wire [11:0] current_reference_input_in,
   input  wire [11:0] drive_current_in,
   input  wire [11:0] rated_current_in,
   input  wire        brake_request_in,
   input  wire        fault_reset_in,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         output_block_out,
   output reg         decel_stop_out,
   output reg         brake_resistor_out,
   output reg         fault_relay_output_out,
   output reg         second_output_out,
   output reg         irq_out
);
   ////////////////////////////////////////////////////////////////////////
   // synchronisers: 1 = contact closed
   reg [4:0]  in_s1_r, in_s2_r;
   reg        brk_s1_r, brk_s2_r, frst_s1_r, frst_s2_r;
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         in_s1_r   <= 5'h00;
         in_s2_r   <= 5'h00;
         brk_s1_r  <= 1'b0;
         brk_s2_r  <= 1'b0;
         frst_s1_r <= 1'b0;
         frst_s2_r <= 1'b0;
      end else if (clk_en_in) begin
         in_s1_r   <= multi_input_in;
         in_s2_r   <= in_s1_r;
         brk_s1_r  <= brake_request_in;
         brk_s2_r  <= brk_s1_r;
         frst_s1_r <= fault_reset_in;
         frst_s2_r <= frst_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   reg [24:0] fsel_r;          // five 5-bit selectors
   reg [1:0]  loss_detect_mode_r;
   reg [1:0]  loss_reaction_select_r;
   reg [10:0] loss_detect_time_r;   // tenths of a second
   reg [2:0]  ref_source_r;
   reg [11:0] voltage_input_min_threshold_r;
   reg [11:0] second_voltage_min_threshold_r;
   reg [11:0] current_input_min_threshold_r;
   reg        braking_limit_enable_r;
   reg [4:0]  braking_duty_setting_r;
   reg [4:0]  relay_output_function_select_r;
   reg [4:0]  second_output_function_select_r;
   reg [3:0]  irq_stat_r, irq_mask_r;
   reg        sw_reset_r;
   reg        ext_trip_r, ovl_trip_r, loss_trip_r, loss_flag_r;
   reg [4:0]  nc_hold_r;       // n.c. trip pending per input

   // bus handshake
   reg        aw_ok_r, w_ok_r;
   reg [31:0] awaddr_r, wdata_r;
   reg [3:0]  wstrb_r;
   wire       wr_go = aw_ok_r & w_ok_r & ~s_axi_bvalid;
   wire [7:0] wa    = awaddr_r[7:0];
   wire       wmap  = (awaddr_r[31:8] == 24'h000000) && (wa[1:0] == 2'b00) &&
                      (wa < `DPS_OFF_ANALOG) && (wa != `DPS_OFF_STATUS);
   wire       wfull = wr_go & wmap & (wstrb_r == 4'hf);
   wire [3:0] ev_set;

   // clip to legal range
   function [4:0] clip5;
      input [4:0] v;
      input [4:0] mx;
      begin
         clip5 = (v > mx) ? mx : v;
      end
   endfunction

   integer k;
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         fsel_r <= {`DPS_FN5_RST, `DPS_FN4_RST, `DPS_FN1_RST, `DPS_FN1_RST, `DPS_FN1_RST}; // RULE4
         loss_detect_mode_r              <= 2'd0;
         loss_reaction_select_r          <= 2'd0;
         loss_detect_time_r              <= `DPS_LT_RST;
         ref_source_r                    <= 3'd0;
         voltage_input_min_threshold_r   <= 12'h000;
         second_voltage_min_threshold_r  <= 12'h000;
         current_input_min_threshold_r   <= 12'h000;
         braking_limit_enable_r          <= 1'b1;
         braking_duty_setting_r          <= `DPS_DUTY_RST;
         relay_output_function_select_r  <= `DPS_OUT_RST;
         second_output_function_select_r <= `DPS_OUT_RST;
         irq_mask_r                      <= 4'h0;
         irq_stat_r                      <= 4'h0;
         sw_reset_r                      <= 1'b0;
         aw_ok_r <= 1'b0;
         w_ok_r  <= 1'b0;
         awaddr_r <= 32'h00000000;
         wdata_r  <= 32'h00000000;
         wstrb_r  <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else if (clk_en_in) begin
         s_axi_awready <= ~aw_ok_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_ok_r & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awready & s_axi_awvalid) begin
            aw_ok_r  <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wready & s_axi_wvalid) begin
            w_ok_r  <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         sw_reset_r <= 1'b0;
         if (wr_go) begin
            aw_ok_r      <= 1'b0;
            w_ok_r       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wfull ? 2'b00 : 2'b10;
         end
         if (wfull) begin
            case (wa)
               `DPS_OFF_CTRL: sw_reset_r <= wdata_r[0];
               `DPS_OFF_FUNC: begin
                  for (k = 0; k < 5; k = k + 1) begin
                     // frozen while n.c. trip pending
                     if (!nc_hold_r[k] && (EXTENDED_IO != 0 || k < 3)) // RULE3 RULE5
                        fsel_r[k*5 +: 5] <= clip5(wdata_r[k*5 +: 5], `DPS_FN_MAX); // RULE4
                  end
               end
               `DPS_OFF_LOSS: begin
                  loss_detect_mode_r     <= (wdata_r[1:0] == 2'd3) ? 2'd2 : wdata_r[1:0];
                  loss_reaction_select_r <= (wdata_r[3:2] == 2'd3) ? 2'd2 : wdata_r[3:2];
                  ref_source_r           <= wdata_r[6:4];
                  loss_detect_time_r     <= (wdata_r[26:16] < `DPS_LT_MIN) ? `DPS_LT_MIN :
                                            (wdata_r[26:16] > `DPS_LT_MAX) ? `DPS_LT_MAX :
                                            wdata_r[26:16]; // RULE11
               end
               `DPS_OFF_THR: begin
                  voltage_input_min_threshold_r  <= wdata_r[11:0];
                  current_input_min_threshold_r  <= wdata_r[27:16];
               end
               `DPS_OFF_BRAKE: begin
                  braking_limit_enable_r <= wdata_r[0];
                  braking_duty_setting_r <= clip5(wdata_r[12:8], `DPS_DUTY_MAX); // RULE15
                  second_voltage_min_threshold_r <= wdata_r[27:16];
               end
               `DPS_OFF_OUTSEL: begin
                  relay_output_function_select_r  <= clip5(wdata_r[4:0], `DPS_OUT_MAX);
                  second_output_function_select_r <= clip5(wdata_r[12:8], `DPS_OUT_MAX);
               end
               `DPS_OFF_IRQ_MASK: irq_mask_r <= wdata_r[3:0];
               default: ;
            endcase
         end
         // set wins over write-one-to-clear
         if (wfull && wa == `DPS_OFF_IRQ_STAT)
            irq_stat_r <= (irq_stat_r & ~wdata_r[3:0]) | ev_set;
         else
            irq_stat_r <= irq_stat_r | ev_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // external trips
   reg [4:0] trip_now;
   integer   j, m;
   always @* begin
      trip_now = 5'h00;
      for (j = 0; j < 5; j = j + 1) begin
         if (EXTENDED_IO != 0 || j < 3) begin // RULE5
            if (fsel_r[j*5 +: 5] == `DPS_FN_TRIP_NO && in_s2_r[j])  trip_now[j] = 1'b1; // RULE1
            if (fsel_r[j*5 +: 5] == `DPS_FN_TRIP_NC && !in_s2_r[j]) trip_now[j] = 1'b1; // RULE2
         end
      end
   end
   wire ext_cond  = |trip_now | |(nc_hold_r & ~in_s2_r);
   wire fault_rst = frst_s2_r | sw_reset_r;

   ////////////////////////////////////////////////////////////////////////
   // overload: excess fills a budget, so delay falls as excess grows
   reg  [31:0] ovl_acc_r;
   wire        over_cur = drive_current_in > rated_current_in;
   wire [31:0] excess   = {20'h00000, drive_current_in - rated_current_in};

   ////////////////////////////////////////////////////////////////////////
   // reference loss
   wire sup_on = (ref_source_r == `DPS_REF_V1) || (ref_source_r == `DPS_REF_VI) ||
                 (ref_source_r == `DPS_REF_COMM); // RULE8
   wire [11:0] vthr = (loss_detect_mode_r == 2'd1) ? {1'b0, voltage_input_min_threshold_r[11:1]}
                                                   : voltage_input_min_threshold_r; // RULE9
   wire [11:0] v2thr = (loss_detect_mode_r == 2'd1) ? {1'b0, second_voltage_min_threshold_r[11:1]}
                                                    : second_voltage_min_threshold_r;
   wire [11:0] ithr = (loss_detect_mode_r == 2'd1) ? {1'b0, current_input_min_threshold_r[11:1]}
                                                   : current_input_min_threshold_r;
   wire loss_raw = sup_on && loss_detect_mode_r != 2'd0 &&
                   ((ref_source_r == `DPS_REF_VI) ?
                     (second_voltage_input_in < v2thr || current_reference_input_in < ithr) // RULE10
                   : (voltage_reference_input_in < vthr)); // RULE9
   reg [31:0] tick_r;
   reg [10:0] loss_cnt_r;
   wire       tick = (tick_r == TENTH_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // braking: duty window plus 15 s cap
   reg [6:0]  duty_cnt_r;
   reg [31:0] brk_cnt_r;
   wire       duty_ok = !braking_limit_enable_r ||
                        (duty_cnt_r < {2'b00, braking_duty_setting_r}); // RULE14 RULE15 RULE16
   wire       brk_cap = brk_cnt_r >= BRK_CYC; // RULE17

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         ext_trip_r  <= 1'b0;
         ovl_trip_r  <= 1'b0;
         loss_trip_r <= 1'b0;
         loss_flag_r <= 1'b0;
         nc_hold_r   <= 5'h00;
         ovl_acc_r   <= 32'h00000000;
         tick_r      <= 32'h00000000;
         loss_cnt_r  <= 11'h000;
         duty_cnt_r  <= 7'h00;
         brk_cnt_r   <= 32'h00000000;
      end else if (clk_en_in) begin
         // hold until contact recloses
         for (m = 0; m < 5; m = m + 1) begin
            if (fsel_r[m*5 +: 5] == `DPS_FN_TRIP_NC && trip_now[m])
               nc_hold_r[m] <= 1'b1; // RULE3
            else if (in_s2_r[m])
               nc_hold_r[m] <= 1'b0; // RULE3
         end
         if (ext_cond)
            ext_trip_r <= 1'b1;
         else if (fault_rst)
            ext_trip_r <= 1'b0; // RULE18
         if (over_cur) begin
            if (ovl_acc_r + excess >= OVL_BUDGET)
               ovl_trip_r <= 1'b1; // RULE6
            else
               ovl_acc_r <= ovl_acc_r + excess;
         end else if (ovl_acc_r != 32'h00000000)
            ovl_acc_r <= ovl_acc_r - 32'h00000001;
         if (!over_cur && fault_rst && ovl_trip_r) begin
            ovl_trip_r <= 1'b0; // RULE18
            ovl_acc_r  <= 32'h00000000;
         end
         tick_r <= tick ? 32'h00000000 : tick_r + 32'h00000001;
         if (!loss_raw)
            loss_cnt_r <= 11'h000;
         else if (tick && loss_cnt_r < loss_detect_time_r)
            loss_cnt_r <= loss_cnt_r + 11'h001;
         loss_flag_r <= loss_raw && loss_cnt_r >= loss_detect_time_r; // RULE11
         if (loss_raw && loss_cnt_r >= loss_detect_time_r && loss_reaction_select_r == 2'd1)
            loss_trip_r <= 1'b1; // RULE12
         else if (!loss_raw && fault_rst)
            loss_trip_r <= 1'b0; // RULE18
         if (tick)
            duty_cnt_r <= (duty_cnt_r == DUTY_PERIOD - 1) ? 7'h00 : duty_cnt_r + 7'h01;
         // cap rearms only when request drops
         if (!brk_s2_r)
            brk_cnt_r <= 32'h00000000;
         else if (tick && !brk_cap)
            brk_cnt_r <= brk_cnt_r + 32'h00000001;
      end
   end

   assign ev_set = {brk_s2_r & brk_cap, loss_flag_r, ovl_trip_r, ext_trip_r};

   ////////////////////////////////////////////////////////////////////////
   // outputs and read port
   function sel_out;
      input [4:0] sel;
      input       ovl;
      input       loss;
      begin
         sel_out = (sel == `DPS_OUT_OVL && ovl) || (sel == `DPS_OUT_LOSS && loss);
      end
   endfunction

   wire [7:0] ra = s_axi_araddr[7:0];
   reg [31:0] rd;
   always @* begin
      case (ra)
         `DPS_OFF_FUNC:     rd = {7'h00, fsel_r};
         `DPS_OFF_LOSS:     rd = {5'h00, loss_detect_time_r, 9'h000, ref_source_r,
                                  loss_reaction_select_r, loss_detect_mode_r};
         `DPS_OFF_THR:      rd = {4'h0, current_input_min_threshold_r, 4'h0,
                                  voltage_input_min_threshold_r};
         // duty field hidden while the limit is off
         `DPS_OFF_BRAKE:    rd = {4'h0, second_voltage_min_threshold_r, 3'h0,
                                  braking_limit_enable_r ? braking_duty_setting_r : 5'h00,
                                  7'h00, braking_limit_enable_r}; // RULE15
         `DPS_OFF_OUTSEL:   rd = {19'h00000, second_output_function_select_r, 3'h0,
                                  relay_output_function_select_r};
         `DPS_OFF_STATUS:   rd = {23'h000000, nc_hold_r, brk_cap, loss_flag_r,
                                  ovl_trip_r, ext_trip_r};
         `DPS_OFF_IRQ_STAT: rd = {28'h0000000, irq_stat_r};
         `DPS_OFF_IRQ_MASK: rd = {28'h0000000, irq_mask_r};
         `DPS_OFF_ANALOG:   rd = {4'h0, current_reference_input_in, 4'h0,
                                  voltage_reference_input_in};
         default:           rd = 32'h00000000;
      endcase
   end
   wire rmap = (s_axi_araddr[31:8] == 24'h000000) && (ra[1:0] == 2'b00) &&
               (ra <= `DPS_OFF_ANALOG);

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         s_axi_arready          <= 1'b0;
         s_axi_rvalid           <= 1'b0;
         s_axi_rdata            <= 32'h00000000;
         s_axi_rresp            <= 2'b00;
         output_block_out       <= 1'b0;
         decel_stop_out         <= 1'b0;
         brake_resistor_out     <= 1'b0;
         fault_relay_output_out <= 1'b0;
         second_output_out      <= 1'b0;
         irq_out                <= 1'b0;
      end else if (clk_en_in) begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arready & s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rmap ? rd : 32'h00000000;
            s_axi_rresp  <= rmap ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
         output_block_out <= ext_trip_r | ovl_trip_r | loss_trip_r; // RULE1 RULE2 RULE12 RULE18
         decel_stop_out   <= loss_flag_r && loss_reaction_select_r == 2'd2; // RULE12
         brake_resistor_out <= brk_s2_r && !brk_cap && duty_ok && !output_block_out; // RULE17
         fault_relay_output_out <= sel_out(relay_output_function_select_r,
                                           ovl_trip_r, loss_flag_r); // RULE7 RULE13
         second_output_out <= sel_out(second_output_function_select_r,
                                      ovl_trip_r, loss_flag_r); // RULE7 RULE13
         irq_out <= |(irq_stat_r & irq_mask_r);
      end
   end
endmodule

// File: tb/dps_checker.sv
`timescale 1ns/100ps
module dps_checker #(
   parameter TENTH_CYC = 10,
   parameter BRK_CYC   = 150
) (
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        fault_reset_in,
   input wire logic        brake_request_in,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        output_block_out,
   input wire logic        decel_stop_out,
   input wire logic        brake_resistor_out
);
   // one tick of slack: tick phase is free against the request
   localparam int CAP = BRK_CYC * TENTH_CYC + TENTH_CYC + 4;
   logic [15:0] cap_cnt_r;
   logic [7:0]  rst_age_r;
   always @(posedge clk_in) begin
      cap_cnt_r <= (sys_rst_in || !brake_resistor_out) ? 16'h0 : cap_cnt_r + 16'h1;
      if (sys_rst_in || fault_reset_in || (s_axi_bvalid && s_axi_bready))
         rst_age_r <= 8'h0;
      else if (rst_age_r != 8'hff)
         rst_age_r <= rst_age_r + 8'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   a_aw_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready too long");
   a_resp_after_addr: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready, 2))
      else $error("late write response");
   a_ar_ready_cause: assert property ($rose(s_axi_arready) |-> $past(s_axi_arvalid))
      else $error("stray arready");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped or changed");
   a_brake_idle: assert property (!brake_request_in [*6] |-> !brake_resistor_out)
      else $error("braking without a request");
   a_brake_blocked: assert property (output_block_out [*3] |-> !brake_resistor_out)
      else $error("braking while output blocked");
   a_block_release: assert property ($fell(output_block_out) |-> rst_age_r < 8'd12)
      else $error("trip released without fault reset");
   a_brake_cap: assert property (cap_cnt_r <= CAP)
      else $error("braking past cap");
   cover property ($rose(output_block_out));
   cover property ($rose(decel_stop_out));
   cover property ($fell(brake_resistor_out) && brake_request_in);
endmodule
bind dps_supervisor dps_checker #(.TENTH_CYC(TENTH_CYC), .BRK_CYC(BRK_CYC)) u_dps_checker (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .fault_reset_in(fault_reset_in),
   .brake_request_in(brake_request_in), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .output_block_out(output_block_out),
   .decel_stop_out(decel_stop_out), .brake_resistor_out(brake_resistor_out));

// File: tb/dps_field_model.sv
`timescale 1ns/100ps
module dps_field_model (
   input  wire logic        clk_in,
   input  wire logic        trip_a_in,
   input  wire logic        trip_b_open_in,
   input  wire logic [11:0] volt_in,
   output var  logic [4:0]  multi_input_out = 5'h10,
   output var  logic [11:0] voltage_reference_input_out = 12'h1f4,
   output var  logic [11:0] current_reference_input_out = 12'hfff
);
   // n.c. contact rests closed
   always @(posedge clk_in) begin
      multi_input_out <= {~trip_b_open_in, trip_a_in, 3'h0};
      voltage_reference_input_out <= volt_in;
   end
endmodule

// File: tb/dps_supervisor_tb_top.sv
`timescale 1ns/100ps
`include "dps_regs.vh"
module dps_supervisor_tb_top;
   logic        clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1;
   logic        brake_request_in = 1'b0, fault_reset_in = 1'b0;
   logic        trip_a = 1'b0, trip_b_open = 1'b0;
   logic [11:0] volt = 12'h1f4, drv_cur = 12'h032, rated = 12'h064;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rv;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  rr;
   wire         awr, wr_rdy, bv, arr, rvd;
   wire  [1:0]  br, rrs;
   wire  [31:0] rdat;
   wire  [4:0]  contacts;
   wire  [11:0] v_ref, i_ref;
   wire  [5:0]  outs;
   int          num_errors = 0, comparisons = 0, wn, t[2];
   always #2.5 clk_in = ~clk_in;
   dps_field_model u_dps_field_model (.clk_in(clk_in), .trip_a_in(trip_a),
      .trip_b_open_in(trip_b_open), .volt_in(volt), .multi_input_out(contacts),
      .voltage_reference_input_out(v_ref), .current_reference_input_out(i_ref));
   dps_supervisor #(.TENTH_CYC(10), .OVL_BUDGET(32'd1000)) u_dps_supervisor (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
      .multi_input_in(contacts), .voltage_reference_input_in(v_ref),
      .second_voltage_input_in(v_ref), .current_reference_input_in(i_ref),
      .drive_current_in(drv_cur), .rated_current_in(rated), .brake_request_in(brake_request_in),
      .fault_reset_in(fault_reset_in), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(awr), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(rvd),
      .s_axi_rready(s_axi_rready), .output_block_out(outs[0]), .decel_stop_out(outs[1]),
      .brake_resistor_out(outs[2]), .fault_relay_output_out(outs[3]),
      .second_output_out(outs[4]), .irq_out(outs[5]));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // outs index: 0 block, 1 decel, 2 brake, 3 relay, 4 second, 5 irq
   task wt(input string nm, input int i, input logic v, input int lim);
      wn = 0;
      while (outs[i] !== v && wn < lim) begin
         @(posedge clk_in);
         wn++;
      end
      chk(nm, v, outs[i]);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_in);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
         if (awr) s_axi_awvalid <= 1'b0;
         if (wr_rdy) s_axi_wvalid <= 1'b0;
      end while (!bv && k < 50);
      s_axi_bready <= 1'b0;
      chk("wr_wait", 1'b1, k < 50);
   endtask
   task rd(input logic [7:0] a);
      int k;
      @(posedge clk_in);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
         if (arr) s_axi_arvalid <= 1'b0;
      end while (!rvd && k < 50);
      // late ready: answer must stand until taken
      s_axi_rready <= 1'b1;
      @(posedge clk_in);
      rv = rdat;
      rr = rrs;
      s_axi_rready <= 1'b0;
      chk("rd_wait", 1'b1, k < 50);
   endtask
   task end_of_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task settle_reset(input int lim);
      repeat (8) @(posedge clk_in);
      fault_reset_in <= 1'b1;
      wt("clr", 0, 0, lim);
      fault_reset_in <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      num_errors++;
      end_of_test;
   end
   initial begin
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rd(`DPS_OFF_FUNC);
      chk("func_rst", {7'h0, `DPS_FN5_RST, `DPS_FN4_RST, 15'h0}, rv);
      rd(`DPS_OFF_BRAKE);
      chk("duty_rst", {`DPS_DUTY_RST, 7'h0, 1'b1}, rv[12:0]);
      rd(`DPS_OFF_LOSS);
      chk("time_rst", `DPS_LT_RST, rv[26:16]);
      wr(`DPS_OFF_OUTSEL, {19'h0, `DPS_OUT_LOSS, 3'h0, `DPS_OUT_OVL});
      wr(`DPS_OFF_FUNC, {7'h0, `DPS_FN_TRIP_NC, `DPS_FN_TRIP_NO, 15'h0});
      wr(`DPS_OFF_IRQ_MASK, 32'hf);
      trip_a <= 1'b1;
      wt("ext_no", 0, 1, 20);
      wt("irq_set", 5, 1, 10);
      trip_a <= 1'b0;
      repeat (10) @(posedge clk_in);
      chk("ext_held", 1'b1, outs[0]);
      wr(`DPS_OFF_CTRL, 32'h1);
      wt("ext_clr", 0, 0, 20);
      wr(`DPS_OFF_IRQ_MASK, 32'h0);
      wt("irq_mask", 5, 0, 10);
      wr(`DPS_OFF_IRQ_STAT, 32'hf);
      wr(`DPS_OFF_IRQ_MASK, 32'hf);
      wt("irq_clr", 5, 0, 4);
      trip_b_open <= 1'b1;
      wt("ext_nc", 0, 1, 20);
      wr(`DPS_OFF_FUNC, {7'h0, 5'h0, `DPS_FN_TRIP_NO, 15'h0});
      rd(`DPS_OFF_FUNC);
      chk("nc_keep", `DPS_FN_TRIP_NC, rv[24:20]);
      trip_b_open <= 1'b0;
      settle_reset(20);
      for (int j = 0; j < 2; j++) begin
         drv_cur <= j ? 12'h12c : 12'h0c8;
         wt("ovl", 0, 1, 60);
         t[j] = wn;
         wt("ovl_relay", 3, 1, 10);
         drv_cur <= 12'h032;
         settle_reset(1500);
      end
      chk("ovl_inverse", 1'b1, t[0] > t[1]);
      wr(`DPS_OFF_THR, 32'h64);
      wr(`DPS_OFF_LOSS, {5'h0, 11'd5, 9'h0, `DPS_REF_V1, 2'd2, 2'd1});
      volt <= 12'h046;
      repeat (90) @(posedge clk_in);
      chk("loss_half", 1'b0, outs[1]);
      wr(`DPS_OFF_LOSS, {5'h0, 11'd5, 9'h0, `DPS_REF_V1, 2'd2, 2'd2});
      wt("loss_decel", 1, 1, 90);
      chk("loss_time", 1'b1, wn >= 40);
      wt("loss_out", 4, 1, 5);
      volt <= 12'h1f4;
      wr(`DPS_OFF_LOSS, 32'h0);
      fault_reset_in <= 1'b1;
      wt("loss_clr", 1, 0, 100);
      fault_reset_in <= 1'b0;
      wr(`DPS_OFF_BRAKE, 32'h0);
      brake_request_in <= 1'b1;
      wt("brake_on", 2, 1, 10);
      wt("brake_cap", 2, 0, 1600);
      chk("brake_len", 1'b1, wn > 1400);
      brake_request_in <= 1'b0;
      rd(8'h40);
      chk("unmapped", 2'b10, rr);
      end_of_test;
   end
endmodule
